// file: rtl/cst_bank.sv
// Behaviour
// - Alert bits 2/1/0 set on input-limit, constant-current, constant-voltage when enabled.
// - Writing the alert register clears the bits written as zero, except those whose condition is live in that cycle.
// - Clearing an alert enable clears its alert bit too.
// - A set alert stays high until cleared or disabled.
// - Read-only nine-bit status at 0x39 follows live conditions.
// - Status bit 8 shows the charger running.
// - Status bit 7 flags a bad cell strap and inhibits charging.
// - Cell strap error reads true while telemetry is off.
// - Status bit 5 flags missing frequency resistor, forced while charger off.
// - Status bit 4 shows thermal shutdown.
// - Status bit 3 shows input overvoltage shutdown.
// - Status bit 2 shows input enough above battery to charge.
// - Status bit 1 shows input above regulator lockout level.
// - Status bit 0 shows internal supply above telemetry lockout.
// - Battery voltage reading, signed, at 0x3A.
// - Input voltage reading, signed, at 0x3B.
// - Output voltage reading, signed, at 0x3C.
// - Battery current reading, signed, at 0x3D, negative when draining.
// - Input current reading, signed, at 0x3E.
// - Die temperature reading, signed, at 0x3F.
`include "cst_regs.svh"

module cst_bank #(
    parameter logic [6:0] DEV_ADDR = 7'h10 // Arbitrary bus address
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        scl,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    input  wire cst_pkg::cst_charge_status_t charge_status,
    input  wire logic [2:0]                  alert_enable,
    input  wire logic                        charger_en,
    input  wire logic                        telemetry_en,
    input  wire cst_pkg::cst_pins_t          status_pins,
    input  wire logic                        meas_valid,
    input  wire cst_pkg::cst_meas_t          meas,
    output logic [2:0]                       alert_flags,
    output logic                             charge_inhibit
);

    // Synchronised bus pins and their previous values
    logic [1:0]                 bus_s;
    logic                       scl_s;
    logic                       sda_s;
    logic                       scl_p_q;
    logic                       sda_p_q;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       start_ev;
    logic                       stop_ev;

    // Serial slave state
    cst_pkg::cst_link_state_t   state_q;
    cst_pkg::cst_link_state_t   nxt_q;
    logic [3:0]                 bitcnt_q;
    logic [7:0]                 shift_q;
    logic [7:0]                 cmd_q;
    logic [7:0]                 wr_lo_q;
    logic                       byte_hi_q;
    logic                       sda_oe_q;
    logic [15:0]                rd_word_q;
    logic [7:0]                 tx_next;
    logic                       byte_done;
    logic                       addr_hit;

    // Register bank contents
    cst_pkg::cst_pins_t         pins_s;
    cst_pkg::cst_meas_t         meas_q;
    logic [2:0]                 alert_q;
    logic [2:0]                 alert_d;
    logic [2:0]                 alert_cond;
    logic [2:0]                 alert_clr;
    logic                       wr_fire;
    logic                       alert_wr;
    logic [15:0]                wr_word;
    logic                       strap_ok;
    logic                       cell_err;
    logic [8:0]                 status_word;
    logic [15:0]                rd_mux;
    logic                       inhibit_q;

    // Pin synchronisers
    cst_sync #(.W(2)) u_bus_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       ({scl, sda_in}),
        .q       (bus_s)
    );

    cst_sync #(.W($bits(cst_pkg::cst_pins_t))) u_pin_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       (status_pins),
        .q       (pins_s)
    );

    // Bus edge and condition decode
    assign scl_s    = bus_s[1];
    assign sda_s    = bus_s[0];
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // Previous pin levels, idle bus is high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Byte and address decode
    assign byte_done = scl_fall & (bitcnt_q == `CST_BYTE_BITS);
    assign addr_hit  = (shift_q[7:1] == DEV_ADDR);
    assign tx_next   = (state_q == cst_pkg::ST_ACK) ? rd_word_q[7:0] :
                       (byte_hi_q ? 8'h00 : rd_word_q[15:8]);

    // Serial slave: sample on rising clock, drive on falling clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= cst_pkg::ST_IDLE;
            nxt_q     <= cst_pkg::ST_IDLE;
            bitcnt_q  <= 4'h0;
            shift_q   <= 8'h00;
            cmd_q     <= 8'h00;
            wr_lo_q   <= 8'h00;
            byte_hi_q <= 1'b0;
            sda_oe_q  <= 1'b0;
            rd_word_q <= 16'h0000;
        end else if (start_ev) begin
            state_q   <= cst_pkg::ST_ADDR;
            bitcnt_q  <= 4'h0;
            byte_hi_q <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else if (stop_ev) begin
            state_q  <= cst_pkg::ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                cst_pkg::ST_ADDR, cst_pkg::ST_CMD, cst_pkg::ST_WR: begin
                    if (scl_rise && bitcnt_q != `CST_BYTE_BITS) begin
                        shift_q  <= {shift_q[6:0], sda_s};
                        bitcnt_q <= bitcnt_q + 4'h1;
                    end else if (byte_done) begin
                        sda_oe_q <= 1'b1; // Acknowledge low
                        state_q  <= cst_pkg::ST_ACK;
                        if (state_q == cst_pkg::ST_ADDR) begin
                            nxt_q <= shift_q[0] ? cst_pkg::ST_RD : cst_pkg::ST_CMD;
                            rd_word_q <= rd_mux;
                            if (!addr_hit) begin
                                sda_oe_q <= 1'b0;
                                state_q  <= cst_pkg::ST_IDLE;
                            end
                        end else if (state_q == cst_pkg::ST_CMD) begin
                            cmd_q     <= shift_q;
                            byte_hi_q <= 1'b0;
                            nxt_q     <= cst_pkg::ST_WR;
                        end else begin
                            wr_lo_q   <= byte_hi_q ? wr_lo_q : shift_q;
                            byte_hi_q <= ~byte_hi_q;
                            nxt_q     <= cst_pkg::ST_WR;
                        end
                    end
                end
                cst_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        state_q  <= nxt_q;
                        bitcnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                        if (nxt_q == cst_pkg::ST_RD) begin
                            shift_q  <= {tx_next[6:0], 1'b0};
                            sda_oe_q <= ~tx_next[7];
                            bitcnt_q <= 4'h1;
                        end
                    end
                end
                cst_pkg::ST_RD: begin
                    if (byte_done) begin
                        sda_oe_q <= 1'b0; // Release for master acknowledge
                        state_q  <= cst_pkg::ST_RD_ACK;
                    end else if (scl_fall) begin
                        sda_oe_q <= ~shift_q[7];
                        shift_q  <= {shift_q[6:0], 1'b0};
                        bitcnt_q <= bitcnt_q + 4'h1;
                    end
                end
                cst_pkg::ST_RD_ACK: begin
                    if (scl_rise && sda_s) begin
                        state_q <= cst_pkg::ST_IDLE; // Master ended the read
                    end else if (scl_fall) begin
                        byte_hi_q <= 1'b1;
                        shift_q   <= {tx_next[6:0], 1'b0};
                        sda_oe_q  <= ~tx_next[7];
                        bitcnt_q  <= 4'h1;
                        state_q   <= cst_pkg::ST_RD;
                    end
                end
                default: begin
                    state_q  <= cst_pkg::ST_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain data pin only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_q;

    // Write completes on the second data byte
    assign wr_fire = (state_q == cst_pkg::ST_WR) & byte_done & byte_hi_q;
    assign wr_word = {shift_q, wr_lo_q};
    assign alert_wr = wr_fire & (cmd_q == `CST_OFS_ALERTS);

    assign alert_cond[`CST_ALERT_ILIM] = (charge_status == cst_pkg::CST_REG_ILIM);
    assign alert_cond[`CST_ALERT_CC]   = (charge_status == cst_pkg::CST_REG_CC);
    assign alert_cond[`CST_ALERT_CV]   = (charge_status == cst_pkg::CST_REG_CV);

    assign alert_clr = {`CST_ALERT_W{alert_wr}} & ~wr_word[2:0];

    assign alert_d = alert_enable & ((alert_q & ~alert_clr) | alert_cond);

    // Alert storage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_q <= `CST_ALERT_RST;
        end else begin
            alert_q <= alert_d;
        end
    end

    assign alert_flags = alert_q;

    assign strap_ok = (pins_s.cell_strap_pins == `CST_STRAP_6V)  |
                      (pins_s.cell_strap_pins == `CST_STRAP_12V) |
                      (pins_s.cell_strap_pins == `CST_STRAP_18V) |
                      (pins_s.cell_strap_pins == `CST_STRAP_24V);
    assign cell_err = ~strap_ok | ~telemetry_en;

    always_comb begin
        status_word = 9'h000;
        status_word[`CST_STS_RUN]  = charger_en;
        status_word[`CST_STS_CELL] = cell_err;
        status_word[`CST_STS_RT]   = pins_s.missing_freq_resistor | ~charger_en;
        status_word[`CST_STS_TSD]  = pins_s.thermal_shutdown;
        status_word[`CST_STS_OVLO] = pins_s.input_ovlo;
        status_word[`CST_STS_VGTB] = pins_s.input_above_battery;
        status_word[`CST_STS_UVLO] = pins_s.input_above_uvlo;
        status_word[`CST_STS_INTV] = pins_s.internal_supply_ok;
    end

    // charging held off on strap error
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            inhibit_q <= 1'b1;
        end else begin
            inhibit_q <= cell_err;
        end
    end

    assign charge_inhibit = inhibit_q;

    // signed results kept whole, sign untouched
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_q <= {6{`CST_MEAS_RST}};
        end else if (meas_valid) begin
            meas_q <= meas;
        end
    end

    assign rd_mux =
        (cmd_q == `CST_OFS_ALERTS) ? {13'h0000, alert_q} :
        (cmd_q == `CST_OFS_STATUS) ? {7'h00, status_word} :
        (cmd_q == `CST_OFS_VBAT)   ? meas_q.battery_voltage_reading :
        (cmd_q == `CST_OFS_VIN)    ? meas_q.input_voltage_reading :
        (cmd_q == `CST_OFS_VOUT)   ? meas_q.output_voltage_reading :
        (cmd_q == `CST_OFS_IBAT)   ? meas_q.battery_current_reading :
        (cmd_q == `CST_OFS_IIN)    ? meas_q.input_current_reading :
        (cmd_q == `CST_OFS_TEMP)   ? meas_q.junction_temp_reading :
        16'h0000;

endmodule

// file: rtl/cst_regs.svh
`ifndef CST_REGS_SVH
`define CST_REGS_SVH

// Command codes of the register bank
`define CST_OFS_ALERTS   8'h38
`define CST_OFS_STATUS   8'h39
`define CST_OFS_VBAT     8'h3A
`define CST_OFS_VIN      8'h3B
`define CST_OFS_VOUT     8'h3C
`define CST_OFS_IBAT     8'h3D
`define CST_OFS_IIN      8'h3E
`define CST_OFS_TEMP     8'h3F

// Alert bit positions
`define CST_ALERT_ILIM   2
`define CST_ALERT_CC     1
`define CST_ALERT_CV     0
`define CST_ALERT_W      3

// Status bit positions
`define CST_STS_RUN      8
`define CST_STS_CELL     7
`define CST_STS_RT       5
`define CST_STS_TSD      4
`define CST_STS_OVLO     3
`define CST_STS_VGTB     2
`define CST_STS_UVLO     1
`define CST_STS_INTV     0

// Reset values
`define CST_MEAS_RST     16'h0000
`define CST_ALERT_RST    3'h0

// Strap level pairs: per pin 00 low, 01 open, 10 high
`define CST_STRAP_6V     4'h0
`define CST_STRAP_12V    4'h2
`define CST_STRAP_18V    4'h8
`define CST_STRAP_24V    4'hA

// Bits per serial byte, acknowledge bit not counted
`define CST_BYTE_BITS    4'h8

`endif

// file: rtl/cst_pkg.sv
package cst_pkg;

    // Regulation status reported by the charge controller
    typedef enum logic [1:0] {
        CST_REG_OTHER,
        CST_REG_CV,
        CST_REG_CC,
        CST_REG_ILIM
    } cst_charge_status_t;

    // Live condition pins from the analog side
    typedef struct packed {
        logic [3:0] cell_strap_pins;
        logic       missing_freq_resistor;
        logic       thermal_shutdown;
        logic       input_ovlo;
        logic       input_above_battery;
        logic       input_above_uvlo;
        logic       internal_supply_ok;
    } cst_pins_t;

    // One set of converter results
    typedef struct packed {
        logic signed [15:0] battery_voltage_reading;
        logic signed [15:0] input_voltage_reading;
        logic signed [15:0] output_voltage_reading;
        logic signed [15:0] battery_current_reading;
        logic signed [15:0] input_current_reading;
        logic signed [15:0] junction_temp_reading;
    } cst_meas_t;

    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WR,
        ST_ACK,
        ST_RD,
        ST_RD_ACK
    } cst_link_state_t;

endpackage

// file: rtl/cst_sync.sv
// Two-stage synchroniser for signals from outside the clock domain
module cst_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// file: sim/cst_bank_chk.sv
`include "cst_regs.svh"

module cst_bank_chk (
    input wire logic                        ref_clk,
    input wire logic                        rst_n,
    input wire logic                        scl,
    input wire logic                        sda_in,
    input wire logic                        sda_out,
    input wire logic                        sda_oe,
    input wire cst_pkg::cst_charge_status_t charge_status,
    input wire logic [2:0]                  alert_enable,
    input wire logic                        charger_en,
    input wire logic                        telemetry_en,
    input wire cst_pkg::cst_pins_t          status_pins,
    input wire logic                        meas_valid,
    input wire cst_pkg::cst_meas_t          meas,
    input wire logic [2:0]                  alert_flags,
    input wire logic                        charge_inhibit
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Strap pins select one of the four legal battery sizes
    wire strap_ok = status_pins.cell_strap_pins inside
        {`CST_STRAP_6V, `CST_STRAP_12V, `CST_STRAP_18V, `CST_STRAP_24V};

    property p_set_cv;
        (charge_status == cst_pkg::CST_REG_CV) && alert_enable[0] |=> alert_flags[0];
    endproperty
    a_set_cv: assert property (p_set_cv) else $error("cv alert not raised");
    property p_set_cc;
        (charge_status == cst_pkg::CST_REG_CC) && alert_enable[1] |=> alert_flags[1];
    endproperty
    a_set_cc: assert property (p_set_cc) else $error("cc alert not raised");
    property p_set_ilim;
        (charge_status == cst_pkg::CST_REG_ILIM) && alert_enable[2] |=> alert_flags[2];
    endproperty
    a_set_ilim: assert property (p_set_ilim) else $error("ilim alert not raised");
    property p_dis_clear;
        1'b1 |=> (alert_flags & ~$past(alert_enable)) == 3'h0;
    endproperty
    a_dis_clear: assert property (p_dis_clear) else $error("disabled alert set");
    // alert stays set; a write clear lands with the acknowledge
    property p_hold;
        (|($past(alert_flags) & ~alert_flags & $past(alert_enable))) |-> $rose(sda_oe);
    endproperty
    a_hold: assert property (p_hold) else $error("alert dropped on its own");
    property p_inh_off;
        !telemetry_en |=> charge_inhibit;
    endproperty
    a_inh_off: assert property (p_inh_off) else $error("inhibit low, telemetry off");
    property p_inh_bad;
        !strap_ok [*3] |-> ##2 charge_inhibit;
    endproperty
    a_inh_bad: assert property (p_inh_bad) else $error("inhibit low, bad strap");
    property p_inh_ok;
        (strap_ok && telemetry_en) [*4] |=> !charge_inhibit;
    endproperty
    a_inh_ok: assert property (p_inh_ok) else $error("inhibit high, good strap");
endmodule

bind cst_bank cst_bank_chk cst_bank_chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .charge_status(charge_status), .alert_enable(alert_enable),
    .charger_en(charger_en), .telemetry_en(telemetry_en), .status_pins(status_pins),
    .meas_valid(meas_valid), .meas(meas), .alert_flags(alert_flags),
    .charge_inhibit(charge_inhibit)
);

// file: sim/cst_host.sv
module cst_host #(
    parameter logic [6:0] ADDR = 7'h10 // Arbitrary bus address
) (
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ns;

    // Six cycles per SCL phase clears the synchroniser minimum of four
    localparam int HALF = 6;

    // Bus idles high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Data moves only while SCL is low, one cycle clear of its edges
    task automatic bit_slot(input logic b, output logic s);
        sda_low <= !b;
        ticks(HALF);
        scl <= 1'b1;
        ticks(HALF);
        s = sda;
        scl <= 1'b0;
        ticks(1);
    endtask

    // Start or repeated start: SDA falls with SCL high
    task automatic start_cond();
        sda_low <= 1'b0;
        ticks(HALF);
        scl <= 1'b1;
        ticks(HALF);
        sda_low <= 1'b1;
        ticks(HALF);
        scl <= 1'b0;
        ticks(1);
    endtask

    task automatic stop_cond();
        sda_low <= 1'b1;
        ticks(HALF);
        scl <= 1'b1;
        ticks(HALF);
        sda_low <= 1'b0;
        ticks(HALF);
    endtask

    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(v[i], s);
        end
        bit_slot(1'b1, s);
        ack = !s;
    endtask

    // Last byte of a read is refused so the device lets go of SDA
    task automatic get_byte(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, v[i]);
        end
        bit_slot(last, s);
    endtask

    // Word write, low byte first
    task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd,
                              input logic [15:0] d, output logic ok);
        logic a0, a1, a2, a3;
        start_cond();
        send_byte({addr, 1'b0}, a0);
        send_byte(cmd, a1);
        send_byte(d[7:0], a2);
        send_byte(d[15:8], a3);
        stop_cond();
        ok = a0 & a1 & a2 & a3;
    endtask

    // Word read through a repeated start
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({ADDR, 1'b0}, a0);
        send_byte(cmd, a1);
        start_cond();
        send_byte({ADDR, 1'b1}, a2);
        get_byte(1'b0, d[7:0]);
        get_byte(1'b1, d[15:8]);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule

// file: sim/cst_bank_tb.sv
`include "cst_regs.svh"

module cst_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [6:0]  ADDR = 7'h10; // Arbitrary bus address
    localparam logic [95:0] MEAS_A = 96'h8123_4C5D_6E7F_FF38_0123_C210;
    localparam logic [95:0] MEAS_B = 96'h1357_2468_0ACE_F00D_7531_0246;

    logic                        ref_clk = 1'b0;
    logic                        rst_n = 1'b0;
    logic                        scl;
    logic                        sda_low;
    logic                        sda_out;
    logic                        sda_oe;
    logic                        charger_en = 1'b1;
    logic                        telemetry_en = 1'b1;
    logic                        meas_valid = 1'b0;
    logic [2:0]                  alert_enable = 3'h7;
    logic [2:0]                  alert_flags;
    logic                        charge_inhibit;
    cst_pkg::cst_charge_status_t charge_status = cst_pkg::CST_REG_OTHER;
    cst_pkg::cst_pins_t          status_pins = '0;
    cst_pkg::cst_meas_t          meas = '0;
    int                          mismatches = 0;
    int                          comparisons = 0;
    logic [11:0]                 sts_case [10] = '{12'hC00, 12'hC3F, 12'hC95, 12'hE2A,
                                     12'hE80, 12'hC40, 12'hFC0, 12'h800, 12'h000, 12'h400};
    // Open-drain wire with pull-up
    wire                         sda_wire = !(sda_oe | sda_low);

    // 10 MHz reference clock
    always #50 ref_clk = ~ref_clk;

    cst_bank #(.DEV_ADDR(ADDR)) cst_bank_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .charge_status(charge_status), .alert_enable(alert_enable),
        .charger_en(charger_en), .telemetry_en(telemetry_en), .status_pins(status_pins),
        .meas_valid(meas_valid), .meas(meas), .alert_flags(alert_flags),
        .charge_inhibit(charge_inhibit)
    );
    cst_host #(.ADDR(ADDR)) cst_host_i (
        .ref_clk(ref_clk), .sda(sda_wire), .scl(scl), .sda_low(sda_low)
    );

    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Read a word, acknowledge included
    task automatic rd_chk(input string what, input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        cst_host_i.read_word(cmd, d, ok);
        check({what, " ack"}, {15'h0, ok}, 16'h0001);
        check(what, d, exp);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
        logic ok;
        cst_host_i.write_word(ADDR, cmd, d, ok);
        check("write ack", {15'h0, ok}, 16'h0001);
    endtask

    // One conversion strobe
    task automatic load_meas(input logic [95:0] v);
        meas <= v;
        meas_valid <= 1'b1;
        ticks(1);
        meas_valid <= 1'b0;
    endtask

    initial begin
        logic ok;
        logic cell_err;
        ticks(2);
        rst_n <= 1'b1;
        ticks(5);
        for (int i = 0; i < 6; i++) begin
            rd_chk("reading reset", `CST_OFS_VBAT + 8'(i), 16'h0000);
        end
        load_meas(MEAS_A);
        for (int i = 0; i < 6; i++) begin
            rd_chk("reading", `CST_OFS_VBAT + 8'(i), MEAS_A[95 - 16 * i -: 16]);
        end
        wr(`CST_OFS_VOUT, 16'hBEEF);
        rd_chk("read-only vout", `CST_OFS_VOUT, MEAS_A[63:48]);
        // A conversion landing in mid-read must not split the word
        fork
            rd_chk("coherent vbat", `CST_OFS_VBAT, MEAS_A[95:80]);
            begin
                ticks(430);
                load_meas(MEAS_B);
            end
        join
        rd_chk("new vbat", `CST_OFS_VBAT, MEAS_B[95:80]);
        // Each regulation state raises its own alert, which then sticks
        alert_enable <= 3'h6;
        charge_status <= cst_pkg::CST_REG_CV;
        ticks(3);
        check("disabled cv alert", {13'h0, alert_flags}, 16'h0000);
        alert_enable <= 3'h7;
        for (int k = 0; k < 3; k++) begin
            charge_status <= cst_pkg::cst_charge_status_t'(2'(k + 1));
            ticks(2);
            charge_status <= cst_pkg::CST_REG_OTHER;
            ticks(3);
            check("alert set", {13'h0, alert_flags}, 16'((2 << k) - 1));
        end
        rd_chk("alert register", `CST_OFS_ALERTS, 16'h0007);
        cst_host_i.write_word(ADDR ^ 7'h01, `CST_OFS_ALERTS, 16'h0000, ok);
        check("foreign ack", {15'h0, ok}, 16'h0000);
        check("alerts kept", {13'h0, alert_flags}, 16'h0007);
        // Host clears one alert with ones everywhere else
        wr(`CST_OFS_ALERTS, 16'hFFFD);
        check("one alert cleared", {13'h0, alert_flags}, 16'h0005);
        alert_enable <= 3'h3;
        ticks(2);
        check("disabled alert", {13'h0, alert_flags}, 16'h0001);
        alert_enable <= 3'h7;
        ticks(2);
        check("alert stays clear", {13'h0, alert_flags}, 16'h0001);
        // Live status across strap codes, flags and enables
        foreach (sts_case[k]) begin
            {charger_en, telemetry_en, status_pins} <= sts_case[k];
            ticks(4);
            cell_err = !sts_case[k][10] || !(sts_case[k][9:6] inside
                {`CST_STRAP_6V, `CST_STRAP_12V, `CST_STRAP_18V, `CST_STRAP_24V});
            check("inhibit", {15'h0, charge_inhibit}, {15'h0, cell_err});
            rd_chk("status", `CST_OFS_STATUS, {7'h0, sts_case[k][11], cell_err, 1'b0,
                sts_case[k][5] | !sts_case[k][11], sts_case[k][4:0]});
        end
        complete_run();
    end

    // Watchdog at about three times the expected run length
    initial begin
        ticks(60000);
        mismatches++;
        complete_run();
    end
endmodule
